// ---- rtl/tie_pkg.sv ----
package tie_pkg;

  // ************************************************************
  // data widths
  // ************************************************************
  localparam int NIB_W = 4;
  localparam int TMR_W = 8;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ************************************************************
  // instruction selects presented by the core decoder
  // ************************************************************
  typedef enum logic [4:0] {
    OP_NOP = 5'h00,
    OP_LOAD_PRESCALER_GATE = 5'h01,
    OP_READ_CTRL_ONE = 5'h02,
    OP_WRITE_CTRL_ONE = 5'h03,
    OP_READ_CTRL_TWO = 5'h04,
    OP_WRITE_CTRL_TWO = 5'h05,
    OP_READ_CTRL_THREE = 5'h06,
    OP_WRITE_CTRL_THREE = 5'h07,
    OP_READ_CTRL_FOUR = 5'h08,
    OP_WRITE_CTRL_FOUR = 5'h09,
    OP_READ_PRESCALER = 5'h0a,
    OP_WRITE_PRESCALER = 5'h0b,
    OP_READ_FIRST_TIMER = 5'h0c,
    OP_WRITE_FIRST_TIMER = 5'h0d,
    OP_READ_SECOND_TIMER = 5'h0e,
    OP_WRITE_SECOND_TIMER = 5'h0f,
    OP_WRITE_SECOND_HIGH_RELOAD = 5'h10,
    OP_WRITE_FIRST_RELOAD_ONLY = 5'h11,
    OP_RELOAD_SECOND_TIMER = 5'h12,
    OP_WRITE_EXTRA_TIMER = 5'h13,
    OP_SKIP_FIRST_TIMER_FLAG = 5'h14,
    OP_SKIP_SECOND_TIMER_FLAG = 5'h15,
    OP_SKIP_THIRD_TIMER_FLAG = 5'h16
  } tie_op_t;

  // ************************************************************
  // interrupt enable bit positions
  // ************************************************************
  localparam int FIRST_IRQ_EN_BIT = 2;
  localparam int SECOND_IRQ_EN_BIT = 3;
  localparam int THIRD_IRQ_EN_BIT = 0;

  // ************************************************************
  // register map (byte addresses)
  // ************************************************************
  localparam logic [ADDR_W-1:0] OFS_IRQ_CTRL_ONE = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CTRL_TWO = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_TIMER_CTRL = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_RELOADS = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_GATE_EXTRA = 8'h14;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [NIB_W-1:0] RST_NIB = 4'h0;
  localparam logic [TMR_W-1:0] RST_TMR = 8'h00;

  // ************************************************************
  // axi responses
  // ************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage

// ---- rtl/tie_axil_slave.sv ----
`timescale 1ns/1ns
module tie_axil_slave (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [tie_pkg::ADDR_W-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [tie_pkg::DATA_W-1:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [tie_pkg::ADDR_W-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [tie_pkg::DATA_W-1:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  output logic wrFire,
  output logic [tie_pkg::ADDR_W-1:0] wrAddr,
  output logic [tie_pkg::DATA_W-1:0] wrData,
  output logic [3:0] wrStrb,
  input wire logic wrOk,
  output logic rdFire,
  output logic [tie_pkg::ADDR_W-1:0] rdAddr,
  input wire logic [tie_pkg::DATA_W-1:0] rdData,
  input wire logic rdOk
);

  // ************************************************************
  // write path
  // ************************************************************
  logic awHeld_reg;
  logic wHeld_reg;

  // address and data may arrive in either order; the write fires once both are held
  assign wrFire = awHeld_reg && wHeld_reg && !s_bvalid;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      awHeld_reg <= 1'b0;
      wrAddr <= '0;
      s_awready <= 1'b1;
    end else if (s_awvalid && s_awready) begin
      awHeld_reg <= 1'b1;
      wrAddr <= s_awaddr;
      s_awready <= 1'b0;
    end else if (wrFire) begin
      awHeld_reg <= 1'b0;
    end else if (s_bvalid && s_bready) begin
      s_awready <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wHeld_reg <= 1'b0;
      wrData <= '0;
      wrStrb <= 4'h0;
      s_wready <= 1'b1;
    end else if (s_wvalid && s_wready) begin
      wHeld_reg <= 1'b1;
      wrData <= s_wdata;
      wrStrb <= s_wstrb;
      s_wready <= 1'b0;
    end else if (wrFire) begin
      wHeld_reg <= 1'b0;
    end else if (s_bvalid && s_bready) begin
      s_wready <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_bvalid <= 1'b0;
      s_bresp <= tie_pkg::RESP_OKAY;
    end else if (wrFire) begin
      s_bvalid <= 1'b1;
      s_bresp <= wrOk ? tie_pkg::RESP_OKAY : tie_pkg::RESP_DECERR;
    end else if (s_bvalid && s_bready) begin
      s_bvalid <= 1'b0;
    end
  end

  // ************************************************************
  // read path
  // ************************************************************
  assign rdFire = s_arvalid && s_arready;
  assign rdAddr = s_araddr;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_arready <= 1'b1;
      s_rvalid <= 1'b0;
      s_rdata <= '0;
      s_rresp <= tie_pkg::RESP_OKAY;
    end else if (rdFire) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b1;
      s_rdata <= rdOk ? rdData : '0;
      s_rresp <= rdOk ? tie_pkg::RESP_OKAY : tie_pkg::RESP_DECERR;
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
      s_arready <= 1'b1;
    end
  end

endmodule

// ---- rtl/tie_timer_exec.sv ----
`timescale 1ns/1ns
// What this block does
// - gate load copies whole accumulator into prescaler gate control; accumulator kept
// - control read instructions copy selected timer control register into accumulator
// - control write instructions copy accumulator into selected timer control register
// - prescaler read puts count high nibble in aux, low nibble in accumulator
// - prescaler write loads aux:accumulator into prescaler counter and its reload together
// - first timer read puts count high nibble in aux, low in accumulator
// - first timer write loads aux:accumulator into first counter and its reload
// - second timer read puts count high nibble in aux, low in accumulator
// - second timer write loads aux:accumulator into second counter and low reload
// - high reload write loads only second high reload from aux:accumulator
// - reload-only write loads only first timer reload; running count untouched
// - reload transfer copies second low reload into second timer counter
// - extra timer write copies accumulator into extra counter and its reload
// - first skip, enable clear: flag set clears it and skips next
// - first skip acts as no-op when irq control one bit 2 set
// - second skip, enable clear: flag set clears it and skips next
// - second skip acts as no-op when irq control one bit 3 set
// - third skip, enable clear: flag set clears it and skips next
// - third skip acts as no-op when irq control two bit 0 set
module tie_timer_exec (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic instrValid,
  input wire tie_pkg::tie_op_t instrOp,
  input wire logic [tie_pkg::NIB_W-1:0] accIn,
  input wire logic [tie_pkg::NIB_W-1:0] auxIn,
  output logic accWe,
  output logic [tie_pkg::NIB_W-1:0] accOut,
  output logic auxWe,
  output logic [tie_pkg::NIB_W-1:0] auxOut,
  output logic carryWe,
  output logic skipNext,
  input wire logic [tie_pkg::TMR_W-1:0] prescalerCount,
  input wire logic [tie_pkg::TMR_W-1:0] firstTimerCount,
  input wire logic [tie_pkg::TMR_W-1:0] secondTimerCount,
  input wire logic firstTimerIrqSet,
  input wire logic secondTimerIrqSet,
  input wire logic thirdTimerIrqSet,
  output logic [tie_pkg::NIB_W-1:0] prescalerGateCtrl,
  output logic [tie_pkg::NIB_W-1:0] timerCtrlOne,
  output logic [tie_pkg::NIB_W-1:0] timerCtrlTwo,
  output logic [tie_pkg::NIB_W-1:0] timerCtrlThree,
  output logic [tie_pkg::NIB_W-1:0] timerCtrlFour,
  output logic prescalerLoad,
  output logic [tie_pkg::TMR_W-1:0] prescalerLoadValue,
  output logic [tie_pkg::TMR_W-1:0] prescalerReload,
  output logic firstTimerLoad,
  output logic [tie_pkg::TMR_W-1:0] firstTimerLoadValue,
  output logic [tie_pkg::TMR_W-1:0] firstTimerReload,
  output logic secondTimerLoad,
  output logic [tie_pkg::TMR_W-1:0] secondTimerLoadValue,
  output logic [tie_pkg::TMR_W-1:0] secondTimerLowReload,
  output logic [tie_pkg::TMR_W-1:0] secondTimerHighReload,
  output logic extraTimerLoad,
  output logic [tie_pkg::NIB_W-1:0] extraTimerLoadValue,
  output logic [tie_pkg::NIB_W-1:0] extraTimerReload,
  output logic firstTimerIrqFlag,
  output logic secondTimerIrqFlag,
  output logic thirdTimerIrqFlag,
  input wire logic [tie_pkg::ADDR_W-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [tie_pkg::DATA_W-1:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [tie_pkg::ADDR_W-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [tie_pkg::DATA_W-1:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);

  // ************************************************************
  // register bus
  // ************************************************************
  logic wrFire;
  logic [tie_pkg::ADDR_W-1:0] wrAddr;
  logic [tie_pkg::DATA_W-1:0] wrData;
  logic [3:0] wrStrb;
  logic wrOk;
  logic rdFire;
  logic [tie_pkg::ADDR_W-1:0] rdAddr;
  logic [tie_pkg::DATA_W-1:0] rdData;
  logic rdOk;
  logic [tie_pkg::NIB_W-1:0] irqCtrlOne_reg;
  logic [tie_pkg::NIB_W-1:0] irqCtrlTwo_reg;

  tie_axil_slave u_bus (
    .clk, .arst_n, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready,
    .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid,
    .s_rready, .wrFire, .wrAddr, .wrData, .wrStrb, .wrOk, .rdFire, .rdAddr, .rdData, .rdOk
  );

  // read-only offsets accept writes silently so a blind init loop never errors
  always_comb begin
    case (wrAddr)
      tie_pkg::OFS_IRQ_CTRL_ONE, tie_pkg::OFS_IRQ_CTRL_TWO, tie_pkg::OFS_FLAGS, tie_pkg::OFS_TIMER_CTRL,
      tie_pkg::OFS_RELOADS, tie_pkg::OFS_GATE_EXTRA: wrOk = 1'b1;
      default: wrOk = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irqCtrlOne_reg <= tie_pkg::RST_NIB;
      irqCtrlTwo_reg <= tie_pkg::RST_NIB;
    end else if (wrFire && wrStrb[0]) begin
      if (wrAddr == tie_pkg::OFS_IRQ_CTRL_ONE) begin
        irqCtrlOne_reg <= wrData[tie_pkg::NIB_W-1:0];
      end
      if (wrAddr == tie_pkg::OFS_IRQ_CTRL_TWO) begin
        irqCtrlTwo_reg <= wrData[tie_pkg::NIB_W-1:0];
      end
    end
  end

  always_comb begin
    rdData = '0;
    rdOk = 1'b1;
    case (rdAddr)
      tie_pkg::OFS_IRQ_CTRL_ONE: rdData = 32'(irqCtrlOne_reg);
      tie_pkg::OFS_IRQ_CTRL_TWO: rdData = 32'(irqCtrlTwo_reg);
      tie_pkg::OFS_FLAGS: rdData = 32'({thirdTimerIrqFlag, secondTimerIrqFlag, firstTimerIrqFlag});
      tie_pkg::OFS_TIMER_CTRL: rdData = 32'({timerCtrlFour, timerCtrlThree, timerCtrlTwo, timerCtrlOne});
      tie_pkg::OFS_RELOADS: rdData = {secondTimerHighReload, secondTimerLowReload, firstTimerReload, prescalerReload};
      tie_pkg::OFS_GATE_EXTRA: rdData = 32'({extraTimerReload, prescalerGateCtrl});
      default: rdOk = 1'b0;
    endcase
  end

  // ************************************************************
  // instruction decode
  // ************************************************************
  logic isOp [23];
  logic [2:0] skipHit;
  logic [2:0] irqEnable;
  logic [2:0] flagSet;
  logic [2:0] flag_reg;

  always_comb begin
    for (int i = 0; i < 23; i++) begin
      isOp[i] = instrValid && (instrOp == tie_pkg::tie_op_t'(i[4:0]));
    end
  end

  assign irqEnable = {irqCtrlTwo_reg[tie_pkg::THIRD_IRQ_EN_BIT],
                      irqCtrlOne_reg[tie_pkg::SECOND_IRQ_EN_BIT],
                      irqCtrlOne_reg[tie_pkg::FIRST_IRQ_EN_BIT]};
  assign flagSet = {thirdTimerIrqSet, secondTimerIrqSet, firstTimerIrqSet};

  // ************************************************************
  // accumulator and aux results
  // ************************************************************
  // results land one cycle late; the core writes back then
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      accWe <= 1'b0;
      auxWe <= 1'b0;
      accOut <= tie_pkg::RST_NIB;
      auxOut <= tie_pkg::RST_NIB;
    end else begin
      accWe <= 1'b0;
      auxWe <= 1'b0;
      if (instrValid) begin
        case (instrOp)
          tie_pkg::OP_READ_CTRL_ONE: begin
            accOut <= timerCtrlOne;
            accWe <= 1'b1;
          end
          tie_pkg::OP_READ_CTRL_TWO: begin
            accOut <= timerCtrlTwo;
            accWe <= 1'b1;
          end
          tie_pkg::OP_READ_CTRL_THREE: begin
            accOut <= timerCtrlThree;
            accWe <= 1'b1;
          end
          tie_pkg::OP_READ_CTRL_FOUR: begin
            accOut <= timerCtrlFour;
            accWe <= 1'b1;
          end
          tie_pkg::OP_READ_PRESCALER: begin
            {auxOut, accOut} <= prescalerCount;
            accWe <= 1'b1;
            auxWe <= 1'b1;
          end
          tie_pkg::OP_READ_FIRST_TIMER: begin
            {auxOut, accOut} <= firstTimerCount;
            accWe <= 1'b1;
            auxWe <= 1'b1;
          end
          tie_pkg::OP_READ_SECOND_TIMER: begin
            {auxOut, accOut} <= secondTimerCount;
            accWe <= 1'b1;
            auxWe <= 1'b1;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ************************************************************
  // control registers
  // ************************************************************
  logic [tie_pkg::NIB_W-1:0] ctrl_reg [4];
  logic [3:0] ctrlWrite;

  assign ctrlWrite = {isOp[tie_pkg::OP_WRITE_CTRL_FOUR], isOp[tie_pkg::OP_WRITE_CTRL_THREE],
                      isOp[tie_pkg::OP_WRITE_CTRL_TWO], isOp[tie_pkg::OP_WRITE_CTRL_ONE]};

  for (genvar g = 0; g < 4; g++) begin : gCtrl
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        ctrl_reg[g] <= tie_pkg::RST_NIB;
      end else if (ctrlWrite[g]) begin
        ctrl_reg[g] <= accIn;
      end
    end
  end

  assign timerCtrlOne = ctrl_reg[0];
  assign timerCtrlTwo = ctrl_reg[1];
  assign timerCtrlThree = ctrl_reg[2];
  assign timerCtrlFour = ctrl_reg[3];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prescalerGateCtrl <= tie_pkg::RST_NIB;
    end else if (isOp[tie_pkg::OP_LOAD_PRESCALER_GATE]) begin
      prescalerGateCtrl <= accIn;
    end
  end

  // ************************************************************
  // prescaler
  // ************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prescalerLoad <= 1'b0;
      prescalerLoadValue <= tie_pkg::RST_TMR;
      prescalerReload <= tie_pkg::RST_TMR;
    end else begin
      prescalerLoad <= isOp[tie_pkg::OP_WRITE_PRESCALER];
      if (isOp[tie_pkg::OP_WRITE_PRESCALER]) begin
        prescalerLoadValue <= {auxIn, accIn};
        prescalerReload <= {auxIn, accIn};
      end
    end
  end

  // ************************************************************
  // first timer
  // ************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      firstTimerLoad <= 1'b0;
      firstTimerLoadValue <= tie_pkg::RST_TMR;
      firstTimerReload <= tie_pkg::RST_TMR;
    end else begin
      firstTimerLoad <= isOp[tie_pkg::OP_WRITE_FIRST_TIMER];
      if (isOp[tie_pkg::OP_WRITE_FIRST_TIMER]) begin
        firstTimerLoadValue <= {auxIn, accIn};
        firstTimerReload <= {auxIn, accIn};
      end else if (isOp[tie_pkg::OP_WRITE_FIRST_RELOAD_ONLY]) begin
        firstTimerReload <= {auxIn, accIn};
      end
    end
  end

  // ************************************************************
  // second timer
  // ************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      secondTimerLoad <= 1'b0;
      secondTimerLoadValue <= tie_pkg::RST_TMR;
      secondTimerLowReload <= tie_pkg::RST_TMR;
      secondTimerHighReload <= tie_pkg::RST_TMR;
    end else begin
      secondTimerLoad <= isOp[tie_pkg::OP_WRITE_SECOND_TIMER] || isOp[tie_pkg::OP_RELOAD_SECOND_TIMER];
      if (isOp[tie_pkg::OP_WRITE_SECOND_TIMER]) begin
        secondTimerLoadValue <= {auxIn, accIn};
        secondTimerLowReload <= {auxIn, accIn};
      end
      if (isOp[tie_pkg::OP_RELOAD_SECOND_TIMER]) begin
        secondTimerLoadValue <= secondTimerLowReload;
      end
      if (isOp[tie_pkg::OP_WRITE_SECOND_HIGH_RELOAD]) begin
        secondTimerHighReload <= {auxIn, accIn};
      end
    end
  end

  // ************************************************************
  // extra timer
  // ************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      extraTimerLoad <= 1'b0;
      extraTimerLoadValue <= tie_pkg::RST_NIB;
      extraTimerReload <= tie_pkg::RST_NIB;
    end else begin
      extraTimerLoad <= isOp[tie_pkg::OP_WRITE_EXTRA_TIMER];
      if (isOp[tie_pkg::OP_WRITE_EXTRA_TIMER]) begin
        extraTimerLoadValue <= accIn;
        extraTimerReload <= accIn;
      end
    end
  end

  // ************************************************************
  // interrupt flags and skips
  // ************************************************************
  // with the enable set the skip is a no-op so the interrupt path owns the flag
  for (genvar f = 0; f < 3; f++) begin : gFlag
    assign skipHit[f] = isOp[tie_pkg::OP_SKIP_FIRST_TIMER_FLAG + f] && flag_reg[f] &&
      !irqEnable[f];
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        flag_reg[f] <= 1'b0;
      end else if (flagSet[f]) begin
        // a timer event in the clearing cycle survives
        flag_reg[f] <= 1'b1;
      end else if (skipHit[f]) begin
        flag_reg[f] <= 1'b0;
      end
    end
  end

  assign firstTimerIrqFlag = flag_reg[0];
  assign secondTimerIrqFlag = flag_reg[1];
  assign thirdTimerIrqFlag = flag_reg[2];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      carryWe <= 1'b0;
      skipNext <= 1'b0;
    end else begin
      // carry is never written by this group
      carryWe <= 1'b0;
      skipNext <= |skipHit;
    end
  end

endmodule

// ---- tb/tie_exec_monitor.sv ----
`timescale 1ns/1ns
module tie_exec_monitor (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic instrValid,
  input wire tie_pkg::tie_op_t instrOp,
  input wire logic [3:0] accIn,
  input wire logic [3:0] auxIn,
  input wire logic [3:0] accOut,
  input wire logic auxWe,
  input wire logic [3:0] auxOut,
  input wire logic carryWe,
  input wire logic skipNext,
  input wire logic [7:0] firstTimerCount,
  input wire logic firstTimerIrqFlag,
  input wire logic [3:0] prescalerGateCtrl,
  input wire logic prescalerLoad,
  input wire logic [7:0] prescalerLoadValue,
  input wire logic [7:0] prescalerReload,
  input wire logic firstTimerLoad,
  input wire logic [7:0] firstTimerReload,
  input wire logic secondTimerLoad,
  input wire logic [7:0] secondTimerLoadValue,
  input wire logic [7:0] secondTimerLowReload
);
  // ****************
  // instruction checks
  // ****************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_gate_load: assert property (
    instrValid && instrOp == tie_pkg::OP_LOAD_PRESCALER_GATE |=> prescalerGateCtrl == $past(accIn))
    else $error("gate load wrong");
  a_presc_write: assert property (
    instrValid && instrOp == tie_pkg::OP_WRITE_PRESCALER |=> prescalerLoad &&
    prescalerLoadValue == {$past(auxIn), $past(accIn)} && prescalerReload == prescalerLoadValue)
    else $error("prescaler write wrong");
  a_first_read: assert property (
    instrValid && instrOp == tie_pkg::OP_READ_FIRST_TIMER |=> auxWe && {auxOut, accOut} == $past(firstTimerCount))
    else $error("first timer read wrong");
  a_reload_only: assert property (
    instrValid && instrOp == tie_pkg::OP_WRITE_FIRST_RELOAD_ONLY |=>
    !firstTimerLoad && firstTimerReload == {$past(auxIn), $past(accIn)}) else $error("reload only wrong");
  a_second_xfer: assert property (
    instrValid && instrOp == tie_pkg::OP_RELOAD_SECOND_TIMER |=>
    secondTimerLoad && secondTimerLoadValue == $past(secondTimerLowReload)) else $error("reload transfer wrong");
  a_skip_zero: assert property (
    instrValid && instrOp == tie_pkg::OP_SKIP_FIRST_TIMER_FLAG && !firstTimerIrqFlag |=> !skipNext)
    else $error("skip with flag clear");
  a_skip_cause: assert property (
    $rose(skipNext) |-> $past(instrValid) && $past(instrOp) inside {tie_pkg::OP_SKIP_FIRST_TIMER_FLAG,
    tie_pkg::OP_SKIP_SECOND_TIMER_FLAG, tie_pkg::OP_SKIP_THIRD_TIMER_FLAG}) else $error("skip without cause");
  a_carry_kept: assert property (carryWe == 1'h0) else $error("carry touched");
endmodule
bind tie_timer_exec tie_exec_monitor u_mon (.clk, .arst_n, .instrValid, .instrOp, .accIn, .auxIn, .accOut,
  .auxWe, .auxOut, .carryWe, .skipNext, .firstTimerCount, .firstTimerIrqFlag, .prescalerGateCtrl,
  .prescalerLoad, .prescalerLoadValue, .prescalerReload, .firstTimerLoad, .firstTimerReload,
  .secondTimerLoad, .secondTimerLoadValue, .secondTimerLowReload);

// ---- tb/tie_core_model.sv ----
`timescale 1ns/1ns
module tie_core_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ld,
  input wire logic [3:0] ldAcc,
  input wire logic [3:0] ldAux,
  input wire logic accWe,
  input wire logic [3:0] accOut,
  input wire logic auxWe,
  input wire logic [3:0] auxOut,
  output logic [3:0] accIn,
  output logic [3:0] auxIn
);
  // ****************
  // core accumulator and aux nibble
  // ****************
  logic [3:0] acc_reg, aux_reg;
  assign accIn = acc_reg;
  assign auxIn = aux_reg;
  // loads never meet a write-back; priority only breaks ties
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_reg <= 4'h0;
      aux_reg <= 4'h0;
    end else if (ld) begin
      acc_reg <= ldAcc;
      aux_reg <= ldAux;
    end else begin
      if (accWe) acc_reg <= accOut;
      if (auxWe) aux_reg <= auxOut;
    end
  end
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/1ns
module tb;
  logic clk = 1'h0, arst_n = 1'h0, instrValid = 1'h0, ld = 1'h0;
  tie_pkg::tie_op_t instrOp = tie_pkg::OP_NOP;
  logic [3:0] ldAcc = 4'h0, ldAux = 4'h0, s_wstrb = 4'hf;
  logic [7:0] prescalerCount = 8'hc3, firstTimerCount = 8'h7e, secondTimerCount = 8'h21;
  logic firstTimerIrqSet = 1'h0, secondTimerIrqSet = 1'h0, thirdTimerIrqSet = 1'h0;
  logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
  logic [31:0] s_wdata = 32'h0;
  logic s_awvalid = 1'h0, s_wvalid = 1'h0, s_bready = 1'h0, s_arvalid = 1'h0, s_rready = 1'h0;
  logic accWe, auxWe, carryWe, skipNext, s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [3:0] accIn, auxIn, accOut, auxOut, prescalerGateCtrl, extraTimerLoadValue, extraTimerReload;
  logic [3:0] timerCtrlOne, timerCtrlTwo, timerCtrlThree, timerCtrlFour;
  logic [7:0] prescalerLoadValue, prescalerReload, firstTimerLoadValue, firstTimerReload;
  logic [7:0] secondTimerLoadValue, secondTimerLowReload, secondTimerHighReload;
  logic [31:0] s_rdata, rd;
  logic [1:0] s_bresp, s_rresp, rsp;
  logic firstTimerIrqFlag, secondTimerIrqFlag, thirdTimerIrqFlag;
  logic prescalerLoad, firstTimerLoad, secondTimerLoad, extraTimerLoad;
  wire logic [2:0] flg = {thirdTimerIrqFlag, secondTimerIrqFlag, firstTimerIrqFlag};
  int nFail = 0, checkCount = 0, cyc = 0;
  tie_timer_exec u_dut (.*);
  tie_core_model u_core (.*);
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      nFail = nFail + 1;
      report_and_stop();
    end
  end
  // ****************
  // access tasks
  // ****************
  task automatic chk(input logic [35:0] g, input logic [35:0] e);
    checkCount = checkCount + 1;
    if (g !== e) begin
      nFail = nFail + 1;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // operands loaded one edge before issue
  task automatic exec(input tie_pkg::tie_op_t op, input logic [3:0] a, input logic [3:0] b);
    @(posedge clk);
    ld <= 1'h1;
    ldAcc <= a;
    ldAux <= b;
    @(posedge clk);
    ld <= 1'h0;
    instrValid <= 1'h1;
    instrOp <= op;
    @(posedge clk);
    instrValid <= 1'h0;
    #1;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'h1;
    s_wvalid <= 1'h1;
    s_bready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_awready) s_awvalid <= 1'h0;
      if (s_wready) s_wvalid <= 1'h0;
    end while (!s_bvalid);
    rsp = s_bresp;
    s_bready <= 1'h0;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge clk);
    s_araddr <= a;
    s_arvalid <= 1'h1;
    s_rready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_arready) s_arvalid <= 1'h0;
    end while (!s_rvalid);
    rd = s_rdata;
    rsp = s_rresp;
    s_rready <= 1'h0;
  endtask
  task automatic report_and_stop();
    if (nFail == 0 && checkCount > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ****************
  // sequence
  // ****************
  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'h1;
    exec(tie_pkg::OP_LOAD_PRESCALER_GATE, 4'h9, 4'h0);
    chk({accWe, prescalerGateCtrl}, 5'h09);
    for (int i = 0; i < 4; i++) begin
      exec(tie_pkg::tie_op_t'(5'h03 + 2 * i), 4'(i + 3), 4'h0);
      exec(tie_pkg::tie_op_t'(5'h02 + 2 * i), 4'h0, 4'h0);
      chk({accWe, auxWe, accOut}, {2'h2, 4'(i + 3)});
    end
    chk({timerCtrlFour, timerCtrlThree, timerCtrlTwo, timerCtrlOne}, 16'h6543);
    exec(tie_pkg::OP_READ_PRESCALER, 4'h0, 4'h0);
    chk({accWe, auxWe, auxOut, accOut}, 10'h3c3);
    exec(tie_pkg::OP_READ_FIRST_TIMER, 4'h0, 4'h0);
    chk({accWe, auxWe, auxOut, accOut}, 10'h37e);
    exec(tie_pkg::OP_READ_SECOND_TIMER, 4'h0, 4'h0);
    chk({accWe, auxWe, auxOut, accOut}, 10'h321);
    exec(tie_pkg::OP_WRITE_PRESCALER, 4'ha, 4'h5);
    chk({prescalerLoad, prescalerLoadValue, prescalerReload}, 17'h15a5a);
    exec(tie_pkg::OP_WRITE_FIRST_TIMER, 4'h1, 4'h2);
    chk({firstTimerLoad, firstTimerLoadValue, firstTimerReload}, 17'h12121);
    exec(tie_pkg::OP_WRITE_FIRST_RELOAD_ONLY, 4'h4, 4'h3);
    chk({firstTimerLoad, firstTimerReload}, 9'h034);
    exec(tie_pkg::OP_WRITE_SECOND_TIMER, 4'h6, 4'h7);
    chk({secondTimerLoad, secondTimerLoadValue, secondTimerLowReload}, 17'h17676);
    exec(tie_pkg::OP_WRITE_SECOND_HIGH_RELOAD, 4'h8, 4'h9);
    chk({secondTimerLoad, secondTimerHighReload, secondTimerLowReload}, 17'h09876);
    exec(tie_pkg::OP_RELOAD_SECOND_TIMER, 4'h0, 4'h0);
    chk({secondTimerLoad, secondTimerLoadValue}, 9'h176);
    exec(tie_pkg::OP_WRITE_EXTRA_TIMER, 4'hb, 4'h0);
    chk({extraTimerLoad, extraTimerLoadValue, extraTimerReload, carryWe}, 10'h376);
    axr(tie_pkg::OFS_RELOADS);
    chk({rsp, rd}, {tie_pkg::RESP_OKAY, 32'h9876345a});
    for (int k = 0; k < 2; k++) begin
      axw(tie_pkg::OFS_IRQ_CTRL_ONE, 32'(k * 12));
      axw(tie_pkg::OFS_IRQ_CTRL_TWO, 32'(k));
      @(posedge clk);
      {thirdTimerIrqSet, secondTimerIrqSet, firstTimerIrqSet} <= 3'h7;
      @(posedge clk);
      {thirdTimerIrqSet, secondTimerIrqSet, firstTimerIrqSet} <= 3'h0;
      for (int i = 0; i < 3; i++) begin
        exec(tie_pkg::tie_op_t'(5'h14 + i), 4'h0, 4'h0);
        chk({skipNext, flg[i]}, {1'(1 - k), 1'(k)});
        exec(tie_pkg::tie_op_t'(5'h14 + i), 4'h0, 4'h0);
        chk({skipNext, flg[i]}, {1'h0, 1'(k)});
      end
    end
    axw(8'h40, 32'h1);
    chk(rsp, tie_pkg::RESP_DECERR);
    axr(8'h40);
    chk({rsp, rd}, {tie_pkg::RESP_DECERR, 32'h0});
    report_and_stop();
  end
endmodule
